// ---- hw/serial_port.sv ----
/*
 Serial port with three frame format registers, run/stop and register-write
 mode changeover, header/terminator framing, control-line handling and NAK
 answer in tool mode. APB slave, single pclk domain; cts is an asynchronous
 pin; foreign_req is a same-clock pulse from the tool protocol decoder.
*/
// Decided for this implementation: the placing of the registers and register access over APB.
// Notes on behaviour
// RL1 - In tool mode any foreign request from outside is answered with a NAK character.
// RL2 - Each channel has a readable mode indication of the active communication type.
// RL3 - With a nonzero format, run means raw transfer and stop means tool communication.
// RL4 - Software writes the format before enabling the raw transfer function.
// RL5 - Software disables raw transfer and writes zero to the format; the port then leaves raw.
// RL6 - Software rewrites the format before re-enabling raw transfer after a changeover.
// RL7 - Software configures a shared port only through the format register.
// RL8 - An RS-485 raw port stays raw across a stop; only the zero-format write changes it. Here clearing CTL_RAW_EN also drops it to idle.
// RL9 - Format bit 0 picks 7/8 data bits, bits 2:1 parity (00 none, 01 odd), bit 3 stop bits.
// RL10 - Format bits 7:4 pick the baud rate from the listed codes.
// RL11 - Format bit 8 sends the header register, reset to STX, before each message.
// RL12 - Format bit 9 sends the terminator register, reset to ETX, after each message.
// RL13 - Format bits 11:10 pick control lines: none, standard, interlink, modem.
// RL14 - Each channel has its own format register written by software.
// RL15 - Parity code 11 selects even parity.
// RL16 - Reserved baud codes keep the previous bit rate.
// RL17 - A zero format hands the port to tool framing at 7 bits, even, 9600 bps.
module serial_port
   import serial_port_pkg::*;
#(
   parameter int CLK_HZ = 25_000_000,
   parameter int FIFO_DEPTH = 16
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic foreign_req,
   input wire logic cts,
   output logic rts,
   output logic txd,
   output logic [5:0] mode_indication
);
   typedef struct packed {
      logic [5:0] ctrl;
      logic [2:0][15:0] fmt;
      logic [7:0] hdr;
      logic [7:0] term;
      logic [16:0] rate_div;
      seq_t seq;
      logic kick;
      logic nak_pending;
      logic cts_s1;
      logic cts_s2;
      logic rts;
      logic [31:0] rdata;
      logic slverr;
   } port_state_t;
   port_state_t s;
   port_state_t next_s;

   localparam logic [17:0] RESET_BAUD = baud_lookup(BAUD_9600, CLK_HZ);

   logic [1:0] ch;
   logic [15:0] fmt_cur;
   logic [15:0] fmt_use;
   logic [17:0] baud;
   mode_t mode;
   logic [5:0] mode_word;
   logic acc;
   logic mapped;
   logic fifo_in_valid;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic fifo_pop;
   logic [8:0] fifo_out_data;
   logic tx_start;
   logic [7:0] tx_byte;
   logic tx_busy;
   logic can_send;
   logic hdr_en;
   logic term_en;

   ////////////////////////////////////////////////////////////////////////////
   // Mode selection
   assign ch = s.ctrl[CTL_CH_LO +: 2];
   assign fmt_cur = (ch == 2'h3) ? FMT_RESET : s.fmt[ch];
   assign hdr_en = fmt_cur[FMT_HDR];
   assign term_en = fmt_cur[FMT_TERM];

   always_comb begin
      if (fmt_cur == FMT_RESET) begin
         mode = s.ctrl[CTL_LINK] ? MODE_LINK : MODE_TOOL; // [RL5] [RL17]
      end else if (!s.ctrl[CTL_RUN] && !s.ctrl[CTL_RS485]) begin
         mode = s.ctrl[CTL_LINK] ? MODE_LINK : MODE_TOOL; // [RL3]
      end else if (s.ctrl[CTL_RAW_EN]) begin
         mode = MODE_RAW; // [RL3] [RL8]
      end else begin
         mode = MODE_IDLE;
      end
   end

   // Unselected channels show idle
   always_comb begin
      mode_word = '0;
      for (int i = 0; i < 3; i++) begin
         if (ch == 2'(i)) begin
            mode_word[2*i +: 2] = mode; // [RL2]
         end
      end
   end
   assign mode_indication = mode_word;

   // Tool mode runs fixed framing; link mode transmits nothing here
   assign fmt_use = (mode == MODE_TOOL) ? TOOL_FORMAT : fmt_cur; // [RL17]
   assign baud = baud_lookup(fmt_use[FMT_BAUD_LO +: 4], CLK_HZ); // [RL10]

   ////////////////////////////////////////////////////////////////////////////
   // APB access
   assign acc = psel && penable;
   assign mapped = (paddr <= OFS_MODE) && (paddr[1:0] == 2'h0);
   assign fifo_in_valid = acc && pwrite && (paddr == OFS_TXDATA);
   // Stall a data write while the FIFO is full
   assign pready = !(fifo_in_valid && !fifo_in_ready);
   assign prdata = s.rdata;
   assign pslverr = s.slverr && acc;
   assign rts = s.rts;

   ////////////////////////////////////////////////////////////////////////////
   // Control-line and transmit sequencing
   always_comb begin
      case (fmt_use[FMT_CTL_LO +: 2])
         CTL_STANDARD: can_send = s.cts_s2; // [RL13]
         CTL_INTERLINK: can_send = s.cts_s2; // [RL13]
         default: can_send = 1'b1; // [RL13]
      endcase
      can_send = can_send && !tx_busy && !s.kick;
   end

   always_comb begin
      next_s = s;
      tx_start = 1'b0;
      tx_byte = fifo_out_data[7:0];
      fifo_pop = 1'b0;
      if (ce) begin
         next_s.cts_s1 = cts;
         next_s.cts_s2 = s.cts_s1;
         next_s.kick = 1'b0;
         if (baud[17]) begin
            next_s.rate_div = baud[16:0]; // [RL16]
         end
         case (fmt_use[FMT_CTL_LO +: 2])
            CTL_NONE: next_s.rts = 1'b0;
            CTL_STANDARD: next_s.rts = (s.seq != SEQ_IDLE) || fifo_out_valid; // [RL13]
            CTL_INTERLINK: next_s.rts = (mode == MODE_RAW); // [RL13]
            default: next_s.rts = 1'b1; // [RL13]
         endcase
         case (s.seq)
            SEQ_IDLE: begin
               if (mode == MODE_TOOL && s.nak_pending && can_send) begin
                  tx_start = 1'b1; // [RL1]
                  tx_byte = NAK_CHAR;
                  next_s.nak_pending = 1'b0;
               end else if (mode == MODE_RAW && fifo_out_valid && can_send) begin
                  next_s.seq = SEQ_DATA;
                  if (hdr_en) begin
                     tx_start = 1'b1; // [RL11]
                     tx_byte = s.hdr;
                  end
               end
            end
            SEQ_DATA: begin
               if (mode != MODE_RAW) begin
                  next_s.seq = SEQ_IDLE;
               end else if (fifo_out_valid && can_send) begin
                  tx_start = 1'b1;
                  fifo_pop = 1'b1;
                  if (fifo_out_data[TXD_LAST]) begin
                     next_s.seq = term_en ? SEQ_TERM : SEQ_IDLE;
                  end
               end
            end
            SEQ_TERM: begin
               if (mode != MODE_RAW) begin
                  next_s.seq = SEQ_IDLE;
               end else if (can_send) begin
                  tx_start = 1'b1; // [RL12]
                  tx_byte = s.term;
                  next_s.seq = SEQ_IDLE;
               end
            end
            default: next_s.seq = SEQ_IDLE;
         endcase
         if (tx_start) begin
            next_s.kick = 1'b1;
         end
         // A new request wins over the clear in the same cycle
         if (foreign_req && mode == MODE_TOOL) begin
            next_s.nak_pending = 1'b1; // [RL1]
         end else if (mode != MODE_TOOL) begin
            next_s.nak_pending = 1'b0;
         end
         // Setup phase captures read data for the access phase
         if (psel && !penable) begin
            next_s.slverr = !mapped;
            next_s.rdata = '0;
            case (paddr)
               OFS_CTRL: next_s.rdata[5:0] = s.ctrl;
               OFS_FMT0: next_s.rdata[15:0] = s.fmt[0];
               OFS_FMT1: next_s.rdata[15:0] = s.fmt[1];
               OFS_FMT2: next_s.rdata[15:0] = s.fmt[2];
               OFS_HDR: next_s.rdata[7:0] = s.hdr;
               OFS_TERM: next_s.rdata[7:0] = s.term;
               OFS_STATUS: next_s.rdata[3:0] = {tx_busy, s.nak_pending, fifo_out_valid,
                  !fifo_in_ready};
               OFS_MODE: next_s.rdata[5:0] = mode_word; // [RL2]
               default: next_s.rdata = '0;
            endcase
         end
         if (acc && pwrite && pready) begin
            case (paddr)
               OFS_CTRL: next_s.ctrl = pwdata[5:0];
               OFS_FMT0: next_s.fmt[0] = pwdata[15:0]; // [RL14]
               OFS_FMT1: next_s.fmt[1] = pwdata[15:0]; // [RL14]
               OFS_FMT2: next_s.fmt[2] = pwdata[15:0]; // [RL14]
               OFS_HDR: next_s.hdr = pwdata[7:0]; // [RL11]
               OFS_TERM: next_s.term = pwdata[7:0]; // [RL12]
               default: next_s.slverr = s.slverr;
            endcase
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '{ctrl: CTRL_RESET, fmt: {3{FMT_RESET}}, hdr: HDR_RESET, term: TERM_RESET,
            rate_div: RESET_BAUD[16:0], seq: SEQ_IDLE, kick: 1'b0, nak_pending: 1'b0,
            cts_s1: 1'b0, cts_s2: 1'b0, rts: 1'b0, rdata: '0, slverr: 1'b0};
      end else begin
         s <= next_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Data path
   tx_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_fifo (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .in_valid(fifo_in_valid),
      .in_ready(fifo_in_ready),
      .in_data(pwdata[8:0]),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_out_data)
   );

   serial_tx u_tx (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .start(tx_start),
      .data(tx_byte),
      .data8(fmt_use[FMT_DLEN]), // [RL9]
      .parity(fmt_use[FMT_PAR_LO +: 2]), // [RL9] [RL15]
      .stop2(fmt_use[FMT_STOP]), // [RL9]
      .div(s.rate_div), // [RL10]
      .busy(tx_busy),
      .txd(txd)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   sequence s_read_mode_setup;
      ce && psel && !penable && !pwrite && paddr == OFS_MODE;
   endsequence
   sequence s_raw_message_start;
      ce && s.seq == SEQ_IDLE && mode == MODE_RAW && fifo_out_valid && can_send;
   endsequence

   a_nak_only_tool: assert property (@(posedge pclk) disable iff (!presetn) // [RL1]
      tx_start && s.seq == SEQ_IDLE && !fifo_out_valid |-> mode == MODE_TOOL
      && tx_byte == NAK_CHAR) else $error("NAK sent outside tool mode");
   a_nak_request_held: assert property (@(posedge pclk) disable iff (!presetn) // [RL1]
      ce && foreign_req && mode == MODE_TOOL |=> s.nak_pending || $past(tx_start))
      else $error("foreign request lost");
   a_mode_read_back: assert property (@(posedge pclk) disable iff (!presetn) // [RL2]
      s_read_mode_setup |=> prdata[5:0] == $past(mode_word) && prdata[31:6] == '0)
      else $error("mode read wrong");
   a_stop_to_tool: assert property (@(posedge pclk) disable iff (!presetn) // [RL3]
      !s.ctrl[CTL_RUN] && !s.ctrl[CTL_RS485] && !s.ctrl[CTL_LINK] |-> mode == MODE_TOOL)
      else $error("stop did not select tool");
   a_zero_leaves_raw: assert property (@(posedge pclk) disable iff (!presetn) // [RL5]
      fmt_cur == FMT_RESET |-> mode != MODE_RAW && fmt_use == TOOL_FORMAT
      || mode == MODE_LINK) else $error("zero format kept raw");
   a_rs485_stays_raw: assert property (@(posedge pclk) disable iff (!presetn) // [RL8]
      s.ctrl[CTL_RAW_EN] && s.ctrl[CTL_RS485] && fmt_cur != FMT_RESET |-> mode == MODE_RAW)
      else $error("rs485 port left raw");
   a_header_first: assert property (@(posedge pclk) disable iff (!presetn) // [RL11]
      s_raw_message_start |-> (tx_start && tx_byte == s.hdr) == hdr_en
      ##1 s.seq == SEQ_DATA) else $error("header not sent first");
   a_term_after_last: assert property (@(posedge pclk) disable iff (!presetn) // [RL12]
      ce && fifo_pop && fifo_out_data[TXD_LAST] && term_en |=> s.seq == SEQ_TERM)
      else $error("terminator skipped");
   a_cts_gates_send: assert property (@(posedge pclk) disable iff (!presetn) // [RL13]
      fmt_use[FMT_CTL_LO +: 2] == CTL_STANDARD && !s.cts_s2 |-> !tx_start)
      else $error("sent without clear to send");
   a_reserved_rate: assert property (@(posedge pclk) disable iff (!presetn) // [RL16]
      ce && !baud[17] |=> s.rate_div == $past(s.rate_div)) else $error("rate changed");
endmodule : serial_port

// ---- hw/serial_port_pkg.sv ----
/*
 Constants, mode and state types and the baud lookup for the serial port.
 Assumes a single pclk domain; register offsets are byte addresses on APB.
*/
package serial_port_pkg;
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_FMT0 = 8'h04;
   localparam logic [7:0] OFS_FMT1 = 8'h08;
   localparam logic [7:0] OFS_FMT2 = 8'h0C;
   localparam logic [7:0] OFS_HDR = 8'h10;
   localparam logic [7:0] OFS_TERM = 8'h14;
   localparam logic [7:0] OFS_TXDATA = 8'h18;
   localparam logic [7:0] OFS_STATUS = 8'h1C;
   localparam logic [7:0] OFS_MODE = 8'h20;
   // Control register fields
   localparam int CTL_RAW_EN = 0;
   localparam int CTL_RUN = 1;
   localparam int CTL_RS485 = 2;
   localparam int CTL_LINK = 3;
   localparam int CTL_CH_LO = 4;
   localparam logic [5:0] CTRL_RESET = 6'h00;
   // Frame format fields
   localparam int FMT_DLEN = 0;
   localparam int FMT_PAR_LO = 1;
   localparam int FMT_STOP = 3;
   localparam int FMT_BAUD_LO = 4;
   localparam int FMT_HDR = 8;
   localparam int FMT_TERM = 9;
   localparam int FMT_CTL_LO = 10;
   localparam int TXD_LAST = 8;
   localparam logic [15:0] FMT_RESET = 16'h0000;
   // 7 data bits, even parity, 1 stop, 9600 bps
   localparam logic [15:0] TOOL_FORMAT = 16'h0086;
   localparam logic [7:0] HDR_RESET = 8'h02;
   localparam logic [7:0] TERM_RESET = 8'h03;
   localparam logic [7:0] NAK_CHAR = 8'h15;
   localparam logic [3:0] BAUD_9600 = 4'h8;
   localparam logic [1:0] CTL_NONE = 2'h0;
   localparam logic [1:0] CTL_STANDARD = 2'h1;
   localparam logic [1:0] CTL_INTERLINK = 2'h2;
   localparam logic [1:0] CTL_MODEM = 2'h3;

   typedef enum logic [1:0] {MODE_IDLE, MODE_RAW, MODE_TOOL, MODE_LINK} mode_t;
   typedef enum logic [1:0] {SEQ_IDLE, SEQ_DATA, SEQ_TERM} seq_t;

   // Valid flag and cycles per bit; reserved codes return zero
   function automatic logic [17:0] baud_lookup(input logic [3:0] code, input int clk_hz);
      int bps;
      bps = 0;
      case (code)
         4'h3: bps = 300;
         4'h4: bps = 600;
         4'h5: bps = 1200;
         4'h7: bps = 4800;
         4'h8: bps = 9600;
         4'h9: bps = 19200;
         4'hA: bps = 38400;
         default: bps = 0;
      endcase
      return (bps == 0) ? 18'h00000 : {1'b1, 17'(clk_hz / bps)};
   endfunction : baud_lookup
endpackage : serial_port_pkg

// ---- hw/serial_tx.sv ----
/*
 Character serializer: start bit, 7 or 8 data bits LSB first, optional parity,
 1 or 2 stop bits. Assumes start is only raised while busy is low.
*/
module serial_tx
   import serial_port_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic start,
   input wire logic [7:0] data,
   input wire logic data8,
   input wire logic [1:0] parity,
   input wire logic stop2,
   input wire logic [16:0] div,
   output logic busy,
   output logic txd
);
   typedef struct packed {
      logic active;
      logic [16:0] cnt;
      logic [3:0] left;
      logic [11:0] sh;
      logic txd;
   } tx_state_t;
   tx_state_t s;
   tx_state_t next_s;
   logic [7:0] dm;
   logic pb;
   logic par_en;
   logic [11:0] f;

   assign busy = s.active;
   assign txd = s.txd;

   always_comb begin
      next_s = s;
      dm = data8 ? data : {1'b0, data[6:0]};
      par_en = parity[0];
      pb = (parity == 2'b01) ? ~^dm : ^dm; // [RL9] [RL15]
      case ({data8, par_en})
         2'b00: f = {4'hF, dm[6:0], 1'b0};
         2'b01: f = {3'h7, pb, dm[6:0], 1'b0};
         2'b10: f = {3'h7, dm, 1'b0};
         default: f = {2'h3, pb, dm, 1'b0};
      endcase
      if (ce) begin
         if (start && !s.active) begin
            next_s.active = 1'b1;
            next_s.txd = f[0];
            next_s.sh = {1'b1, f[11:1]};
            // Bits after the start bit; stop2 adds one more high bit [RL9]
            next_s.left = 4'h8 + {3'h0, data8} + {3'h0, par_en} + {3'h0, stop2};
            next_s.cnt = div - 17'h00001;
         end else if (s.active) begin
            if (s.cnt != '0) begin
               next_s.cnt = s.cnt - 17'h00001;
            end else if (s.left == '0) begin
               next_s.active = 1'b0;
               next_s.txd = 1'b1;
            end else begin
               next_s.txd = s.sh[0];
               next_s.sh = {1'b1, s.sh[11:1]};
               next_s.left = s.left - 4'h1;
               next_s.cnt = div - 17'h00001;
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '{active: 1'b0, cnt: '0, left: '0, sh: '1, txd: 1'b1};
      end else begin
         s <= next_s;
      end
   end

   a_start_bit_low: assert property (@(posedge pclk) disable iff (!presetn)
      ce && start && !s.active |=> !txd && busy) else $error("no start bit"); // [RL9]
endmodule : serial_tx

// ---- hw/tx_fifo.sv ----
/*
 Synchronous FIFO with valid/ready on both sides.
 Assumes one clock; ce low freezes all state.
*/
module tx_fifo
   import serial_port_pkg::*;
#(
   parameter int WIDTH = 9,
   parameter int DEPTH = 16
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wptr;
      logic [AW-1:0] rptr;
      logic [AW:0] count;
   } fifo_state_t;
   fifo_state_t s;
   fifo_state_t next_s;
   logic push;
   logic pop;

   assign in_ready = (s.count != (AW+1)'(DEPTH));
   assign out_valid = (s.count != '0);
   assign out_data = s.mem[s.rptr];
   assign push = ce && in_valid && in_ready;
   assign pop = ce && out_valid && out_ready;

   always_comb begin
      next_s = s;
      if (push) begin
         next_s.mem[s.wptr] = in_data;
         next_s.wptr = (s.wptr == AW'(DEPTH-1)) ? '0 : s.wptr + 1'b1;
      end
      if (pop) begin
         next_s.rptr = (s.rptr == AW'(DEPTH-1)) ? '0 : s.rptr + 1'b1;
      end
      if (push && !pop) begin
         next_s.count = s.count + 1'b1;
      end else if (pop && !push) begin
         next_s.count = s.count - 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   a_fifo_no_overrun: assert property (@(posedge pclk) disable iff (!presetn)
      s.count <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule : tx_fifo

// ---- test/serial_peer.sv ----
/*
 Far-end serial equipment: decodes txd frames, checks parity and stop bits.
 Assumes the bench sets fmt and bit_cycles before each frame starts.
*/
module serial_peer (
   input wire logic pclk,
   input wire logic txd,
   input wire logic stall,
   input wire logic [15:0] fmt,
   input wire logic [7:0] bit_cycles,
   output logic cts,
   output logic [7:0] last_char,
   output int n_chars,
   output int n_bad
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] sh;
   // Clear to send unless stalling
   assign cts = ~stall;
   initial begin
      n_chars = 0;
      n_bad = 0;
      last_char = 8'h00;
   end
   always begin
      @(negedge txd);
      repeat (bit_cycles / 2) @(posedge pclk);
      sh = 8'h00;
      for (int i = 0; i < 8; i++) begin
         if (i < 7 || fmt[0]) begin
            repeat (bit_cycles) @(posedge pclk);
            sh[i] = txd;
         end
      end
      if (fmt[1]) begin
         repeat (bit_cycles) @(posedge pclk);
         if (txd !== (fmt[2] ? ^sh : ~^sh)) n_bad++;
      end
      for (int i = 0; i <= 32'(fmt[3]); i++) begin
         repeat (bit_cycles) @(posedge pclk);
         if (txd !== 1'b1) n_bad++;
      end
      last_char = sh;
      n_chars++;
   end
endmodule : serial_peer

// ---- test/tb.sv ----
/*
 Self-checking bench: APB master tasks, far-end peer, one task per scenario.
 Assumes zero-wait APB except a full FIFO; CLK_HZ lowered for short bits.
*/
module tb
   import serial_port_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, rd;
   logic pready, pslverr, rts, txd, cts, err;
   logic foreign_req = 1'b0;
   logic ce = 1'b1;
   logic stall = 1'b0;
   logic [5:0] mode_indication;
   logic [15:0] peer_fmt = TOOL_FORMAT;
   logic [7:0] bit_cycles = 8'h28;
   logic [7:0] last_char;
   int n_chars, n_bad, base;
   int n_mismatch = 0;
   int compares = 0;
   int cycles = 0;
   always #20 pclk = ~pclk;
   serial_port #(.CLK_HZ(384000), .FIFO_DEPTH(16)) dut (
      .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .foreign_req(foreign_req), .cts(cts),
      .rts(rts), .txd(txd), .mode_indication(mode_indication));
   serial_peer peer (.pclk(pclk), .txd(txd), .stall(stall), .fmt(peer_fmt),
      .bit_cycles(bit_cycles), .cts(cts), .last_char(last_char),
      .n_chars(n_chars), .n_bad(n_bad));
   ////////////////////////////////////////
   task automatic results();
      if (n_mismatch == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : results
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Access ends at the edge that sees pready high
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chk(rd, exp);
   endtask : rdchk
   task automatic chkmode(input logic [1:0] m);
      @(negedge pclk);
      chk({26'h0, mode_indication}, {30'h0, m});
   endtask : chkmode
   task automatic expect_char(input logic [7:0] exp);
      int b;
      b = n_chars;
      while (n_chars == b) @(posedge pclk);
      chk({24'h0, last_char}, {24'h0, exp});
   endtask : expect_char
   ////////////////////////////////////////
   task automatic t_reset();
      for (int i = 0; i < 3; i++) rdchk(OFS_FMT0 + 8'(4 * i), 32'h0);
      // Writes are ignored while ce is low
      ce <= 1'b0;
      wr(OFS_HDR, 32'h0000_0055);
      ce <= 1'b1;
      rdchk(OFS_HDR, 32'h0000_0002);
      rdchk(OFS_TERM, 32'h0000_0003);
      chkmode(2'h2);
      apb(1'b0, 8'h24, 32'h0);
      chk({31'h0, err}, 32'h1);
   endtask : t_reset
   task automatic t_nak();
      foreign_req <= 1'b1;
      @(posedge pclk);
      foreign_req <= 1'b0;
      expect_char(NAK_CHAR);
   endtask : t_nak
   task automatic t_raw();
      wr(OFS_HDR, 32'h0000_003C);
      wr(OFS_TERM, 32'h0000_003E);
      wr(OFS_FMT0, 32'h0000_03A3);
      wr(OFS_CTRL, 32'h0000_0003);
      chkmode(2'h1);
      apb(1'b0, OFS_MODE, 32'h0);
      chk({30'h0, rd[1:0]}, 32'h1);
      peer_fmt <= 16'h03A3;
      bit_cycles <= 8'h0A;
      wr(OFS_TXDATA, 32'h0000_0141);
      expect_char(8'h3C);
      expect_char(8'h41);
      expect_char(8'h3E);
   endtask : t_raw
   task automatic t_runstop();
      wr(OFS_CTRL, 32'h0000_0001);
      chkmode(2'h2);
      wr(OFS_CTRL, 32'h0000_0007);
      wr(OFS_CTRL, 32'h0000_0005);
      chkmode(2'h1);
      wr(OFS_CTRL, 32'h0000_000C);
      wr(OFS_FMT0, 32'h0);
      chkmode(2'h3);
      wr(OFS_CTRL, 32'h0);
      chkmode(2'h2);
   endtask : t_runstop
   task automatic t_chan();
      wr(OFS_FMT1, 32'h0000_00A3);
      wr(OFS_CTRL, 32'h0000_0013);
      rdchk(OFS_MODE, 32'h0000_0004);
      chk({26'h0, mode_indication}, 32'h0000_0004);
      foreign_req <= 1'b1;
      @(posedge pclk);
      foreign_req <= 1'b0;
      rdchk(OFS_STATUS, 32'h0);
      wr(OFS_CTRL, 32'h0000_0023);
      rdchk(OFS_MODE, 32'h0000_0020);
      chk({26'h0, mode_indication}, 32'h0000_0020);
   endtask : t_chan
   task automatic t_even();
      wr(OFS_FMT0, 32'h0000_00AF);
      wr(OFS_CTRL, 32'h0000_0003);
      wr(OFS_FMT0, 32'h0000_006F);
      peer_fmt <= 16'h006F;
      wr(OFS_TXDATA, 32'h0000_01C3);
      expect_char(8'hC3);
   endtask : t_even
   task automatic t_ctl();
      for (int c = 0; c < 4; c++) begin
         wr(OFS_FMT0, 32'h0000_00A3 | (32'(c) << 10));
         repeat (3) @(posedge pclk);
         chk({31'h0, rts}, {31'h0, c >= 2});
      end
   endtask : t_ctl
   task automatic t_fifo();
      stall <= 1'b1;
      peer_fmt <= 16'h04A3;
      wr(OFS_FMT0, 32'h0000_04A3);
      base = n_chars;
      for (int i = 0; i < 16; i++) wr(OFS_TXDATA, 32'h0000_0100 + 32'(i));
      rdchk(OFS_STATUS, 32'h0000_0003);
      chk({31'h0, rts}, 32'h1);
      fork
         begin
            repeat (40) @(posedge pclk);
            stall <= 1'b0;
         end
      join_none
      wr(OFS_TXDATA, 32'h0000_0155);
      chk(32'(n_chars - base), 32'h0);
      while (n_chars < base + 17) @(posedge pclk);
      chk({24'h0, last_char}, 32'h0000_0055);
      repeat (20) @(posedge pclk);
      rdchk(OFS_STATUS, 32'h0);
      chk({31'h0, rts}, 32'h0);
   endtask : t_fifo
   ////////////////////////////////////////
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         n_mismatch++;
         results();
      end
   end
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_nak();
      t_raw();
      t_runstop();
      t_chan();
      t_even();
      t_ctl();
      t_fifo();
      chk(32'(n_bad), 32'h0);
      results();
   end
endmodule : tb
